// ### hdl/t8sp_regs.svh
// Purpose: Register map and constants of the shared-prescaler timer
// Assumes: 25 MHz clk, four clocks per instruction cycle
// Notes: Offsets are byte addresses on the plain register port
//
// What this block does
// (R01) Source bit clear: count every instruction cycle when prescaler unassigned.
// (R02) A count write suppresses counting for the next two instruction cycles.
// (R03) Source bit set: count edges of the external count pin.
// (R04) Edge bit picks counting edge: clear rising, set falling.
// (R05) Assign bit routes prescaler: clear to counter, set to watchdog; never visible.
// (R06) Ratio field divides the counter source from 1:2 to 1:256.
// (R07) Ratio code 000 divides by two, each step doubles, 111 by 256.
// (R08) Count wrapping FFh to 00h sets the overflow flag, bit 2.
// (R09) Overflow request masked while enable bit 5 is clear; flag still sets. Here mask register bit 0 still lets the overflow event raise irq.
// (R10) Software clears the overflow flag itself before re-enabling the request.
// (R11) Sleep halts the counter, so no overflow and no wake from it.
// (R12) External path sampled on phase two and phase four before counting.
// (R13) Exactly one 8-bit prescaler, before the counter or after the watchdog.
// (R14) Watchdog unscaled while prescaler serves counter; counter undivided otherwise.
// (R15) Any count write clears the prescaler while it serves the counter.
// (R16) Watchdog clear resets the prescaler while it serves the watchdog.
// (R17) Prescaler assignment may change at any time without reset.
// (R18) Counter to watchdog: write count, clear watchdog, then write option.
// (R19) Watchdog to counter: clear watchdog, then write option with assign clear.
`ifndef T8SP_REGS_SVH
`define T8SP_REGS_SVH

`define T8SP_ADDR_COUNT 8'h01
`define T8SP_ADDR_INTCTL 8'h0B
`define T8SP_ADDR_OPTION 8'h81
`define T8SP_ADDR_PINDIR 8'h85
`define T8SP_ADDR_STAT 8'h90
`define T8SP_ADDR_MASK 8'h91

`define T8SP_COUNT_RESET 8'h00
`define T8SP_INTCTL_RESET 8'h00
`define T8SP_OPTION_RESET 8'hFF
`define T8SP_PINDIR_RESET 8'h3F
`define T8SP_PINDIR_MASK 8'h3F
`define T8SP_EV_RESET 2'h0

`define T8SP_INTCTL_FLAG 2
`define T8SP_INTCTL_EN 5
`define T8SP_EV_OVF 0
`define T8SP_EV_EDGE 1

`define T8SP_COUNT_MAX 8'hFF
`define T8SP_PH_RESET 2'h0
`define T8SP_PH_TWO 2'h1
`define T8SP_PH_FOUR 2'h3
// Option resets with edge bit set, so an idle low pin reads as level one
`define T8SP_LVL_RESET 1'b1

`endif

// ### hdl/t8sp_pkg.sv
// Purpose: Types shared by the shared-prescaler timer
// Assumes: Option layout matches the option register bit order
// Notes: Register port travels as one struct
package t8sp_pkg;

	typedef struct packed {
		logic pullup_off;
		logic int_edge;
		logic count_source_select;
		logic source_edge_select;
		logic scaler_assign;
		logic [2:0] scale_ratio;
	} t8sp_opt_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} t8sp_req_t;

	typedef enum logic [1:0] {
		hold_run,
		hold_first,
		hold_second
	} t8sp_hold_t;

endpackage

// ### hdl/t8sp_top.sv
// Purpose: 8-bit timer/counter with prescaler shared with the watchdog
// Assumes: Watchdog base tick and clear come from same-clock logic
// Notes: Prescaler is synchronous here, not a ripple counter
`include "t8sp_regs.svh"

module t8sp_top #(
	parameter int PRE_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire t8sp_pkg::t8sp_req_t req,
	output logic [7:0] rdata,
	input wire logic ext_count_pin,
	input wire logic sleep_mode,
	input wire logic watchdog_clear_op,
	input wire logic watchdog_tick,
	output logic watchdog_timeout,
	output logic irq
);

	if (PRE_W < 8) begin : g_chk
		$error("Prescaler narrower than the largest ratio");
	end

	logic [1:0] ph_ff;
	logic [1:0] nxt_ph;
	logic pin_s1_ff;
	logic pin_s2_ff;
	logic pin_prev_ff;
	logic samp_ff;
	logic nxt_samp;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic [PRE_W-1:0] pre_ff;
	logic [PRE_W-1:0] nxt_pre;
	t8sp_pkg::t8sp_hold_t hold_ff;
	t8sp_pkg::t8sp_hold_t nxt_hold;
	t8sp_pkg::t8sp_opt_t opt_ff;
	t8sp_pkg::t8sp_opt_t nxt_opt;
	logic [7:0] intc_ff;
	logic [7:0] nxt_intc;
	logic [7:0] dir_ff;
	logic [7:0] nxt_dir;
	logic [1:0] stat_ff;
	logic [1:0] nxt_stat;
	logic [1:0] mask_ff;
	logic [1:0] nxt_mask;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic irq_ff;
	logic nxt_irq;
	logic wdto_ff;
	logic nxt_wdto;

	logic instr_tick;
	logic sample_en;
	logic wr_cnt;
	logic pin_lvl;
	logic ext_edge;
	logic [PRE_W-1:0] rmask;
	logic pre_in;
	logic pre_wrap;
	logic pre_clr;
	logic ext_src;
	logic ext_tick;
	logic cnt_tick;
	logic ovf;

	assign rdata = rdata_ff;
	assign irq = irq_ff;
	assign watchdog_timeout = wdto_ff;

	// Phases and event sources
	always_comb begin
		nxt_ph = ph_ff + 2'h1;
		instr_tick = (ph_ff == `T8SP_PH_FOUR);
		sample_en = (ph_ff == `T8SP_PH_TWO) || instr_tick; // R12
		wr_cnt = req.wr && (req.addr == `T8SP_ADDR_COUNT);
		// Invert so that a rise of pin_lvl is always the chosen edge
		pin_lvl = pin_s2_ff ^ opt_ff.source_edge_select; // R04
		ext_edge = pin_lvl && !pin_prev_ff;
		rmask = {PRE_W{1'b1}} >> (PRE_W - 1 - int'(opt_ff.scale_ratio)); // R06 R07
		if (opt_ff.scaler_assign) begin // R05 R13
			pre_in = watchdog_tick;
		end else if (opt_ff.count_source_select) begin
			pre_in = ext_edge && !sleep_mode;
		end else begin
			pre_in = instr_tick && !sleep_mode;
		end
		pre_wrap = pre_in && ((pre_ff & rmask) == rmask);
		pre_clr = opt_ff.scaler_assign ? watchdog_clear_op : wr_cnt; // R15 R16
		// Undivided pin or prescaler tap, both resampled on the phases
		ext_src = opt_ff.scaler_assign ? pin_lvl : pre_ff[opt_ff.scale_ratio]; // R14
		nxt_samp = sample_en ? ext_src : samp_ff; // R12
		ext_tick = sample_en && ext_src && !samp_ff;
	end

	// Count and its inhibit window
	always_comb begin
		nxt_hold = hold_ff;
		unique case (hold_ff)
			t8sp_pkg::hold_run: nxt_hold = t8sp_pkg::hold_run;
			t8sp_pkg::hold_first: if (instr_tick) begin
				nxt_hold = t8sp_pkg::hold_second;
			end
			t8sp_pkg::hold_second: if (instr_tick) begin
				nxt_hold = t8sp_pkg::hold_run;
			end
		endcase
		if (wr_cnt) begin
			nxt_hold = t8sp_pkg::hold_first; // R02
		end
		cnt_tick = 1'b0;
		if (!sleep_mode && hold_ff == t8sp_pkg::hold_run) begin // R11
			if (opt_ff.count_source_select) begin
				cnt_tick = ext_tick; // R03
			end else if (opt_ff.scaler_assign) begin
				cnt_tick = instr_tick; // R01
			end else begin
				cnt_tick = pre_wrap; // R06
			end
		end
		ovf = cnt_tick && (cnt_ff == `T8SP_COUNT_MAX) && !wr_cnt;
		nxt_cnt = cnt_ff;
		if (wr_cnt) begin
			nxt_cnt = req.wdata; // R02
		end else if (cnt_tick) begin
			nxt_cnt = cnt_ff + 8'h01;
		end
		nxt_pre = pre_ff;
		if (pre_clr) begin
			nxt_pre = '0;
		end else if (pre_in) begin
			nxt_pre = pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
		end
		// Without the prescaler each base tick reaches the watchdog
		nxt_wdto = 1'b0;
		if (opt_ff.scaler_assign) begin
			nxt_wdto = pre_wrap && !pre_clr; // R14
		end else begin
			nxt_wdto = watchdog_tick; // R14
		end
	end

	// Software registers, events and read port
	always_comb begin
		nxt_opt = opt_ff;
		nxt_intc = intc_ff;
		nxt_dir = dir_ff;
		nxt_mask = mask_ff;
		nxt_stat = stat_ff;
		nxt_rdata = 8'h00;
		if (req.wr) begin
			unique case (req.addr)
				`T8SP_ADDR_OPTION: nxt_opt = req.wdata; // R17
				`T8SP_ADDR_INTCTL: nxt_intc = req.wdata;
				`T8SP_ADDR_PINDIR: nxt_dir = req.wdata & `T8SP_PINDIR_MASK;
				`T8SP_ADDR_MASK: nxt_mask = req.wdata[1:0];
				default: nxt_opt = opt_ff;
			endcase
		end
		if (req.rd) begin
			unique case (req.addr)
				`T8SP_ADDR_COUNT: nxt_rdata = cnt_ff;
				`T8SP_ADDR_INTCTL: nxt_rdata = intc_ff;
				`T8SP_ADDR_OPTION: nxt_rdata = opt_ff;
				`T8SP_ADDR_PINDIR: nxt_rdata = dir_ff;
				`T8SP_ADDR_STAT: nxt_rdata = {6'h00, stat_ff};
				`T8SP_ADDR_MASK: nxt_rdata = {6'h00, mask_ff};
				default: nxt_rdata = 8'h00;
			endcase
			if (req.addr == `T8SP_ADDR_STAT) begin
				nxt_stat = `T8SP_EV_RESET;
			end
		end
		// Hardware set beats a software clear in the same cycle
		if (ovf) begin
			nxt_intc[`T8SP_INTCTL_FLAG] = 1'b1; // R08
			nxt_stat[`T8SP_EV_OVF] = 1'b1;
		end
		if (cnt_tick && opt_ff.count_source_select) begin
			nxt_stat[`T8SP_EV_EDGE] = 1'b1;
		end
		// Flag stays until software clears it, enable gates only the request
		nxt_irq = (intc_ff[`T8SP_INTCTL_FLAG] && intc_ff[`T8SP_INTCTL_EN])
			|| (|(stat_ff & mask_ff)); // R09 R10
	end

	always_ff @(posedge clk) begin
		pin_s1_ff <= ext_count_pin;
		pin_s2_ff <= pin_s1_ff;
		if (!rst_n) begin
			ph_ff <= `T8SP_PH_RESET;
			pin_prev_ff <= `T8SP_LVL_RESET;
			samp_ff <= `T8SP_LVL_RESET;
			cnt_ff <= `T8SP_COUNT_RESET;
			pre_ff <= '0;
			hold_ff <= t8sp_pkg::hold_run;
			opt_ff <= `T8SP_OPTION_RESET;
			intc_ff <= `T8SP_INTCTL_RESET;
			dir_ff <= `T8SP_PINDIR_RESET;
			stat_ff <= `T8SP_EV_RESET;
			mask_ff <= `T8SP_EV_RESET;
			rdata_ff <= 8'h00;
			irq_ff <= 1'b0;
			wdto_ff <= 1'b0;
		end else begin
			ph_ff <= nxt_ph;
			pin_prev_ff <= pin_lvl;
			samp_ff <= nxt_samp;
			cnt_ff <= nxt_cnt;
			pre_ff <= nxt_pre;
			hold_ff <= nxt_hold;
			opt_ff <= nxt_opt;
			intc_ff <= nxt_intc;
			dir_ff <= nxt_dir;
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
			wdto_ff <= nxt_wdto;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	chk_write_inhibit: assert property ( // R02
		wr_cnt |=> hold_ff == t8sp_pkg::hold_first ##0
			(!wr_cnt throughout (cnt_ff == $past(req.wdata))[*4])
	) else $error("Count moved inside the write inhibit");

	chk_timer_mode: assert property ( // R01
		instr_tick && !opt_ff.count_source_select && opt_ff.scaler_assign
		&& !sleep_mode && hold_ff == t8sp_pkg::hold_run && !wr_cnt
		|=> cnt_ff == $past(cnt_ff) + 8'h01
	) else $error("Timer mode missed an instruction cycle");

	chk_ext_phase: assert property ( // R12
		$changed(cnt_ff) && opt_ff.count_source_select && !$past(wr_cnt)
		|-> $past(sample_en) && $past(ph_ff) != `T8SP_PH_RESET
	) else $error("External count advanced off phase two or four");

	chk_edge_select: assert property ( // R04
		opt_ff.count_source_select && opt_ff.scaler_assign && $rose(samp_ff)
		|-> $past(pin_s2_ff ^ opt_ff.source_edge_select)
	) else $error("Counted the unselected external edge");

	chk_ovf_flag: assert property ( // R08
		cnt_ff == `T8SP_COUNT_MAX && cnt_tick && !wr_cnt
		|=> cnt_ff == 8'h00 && intc_ff[`T8SP_INTCTL_FLAG]
	) else $error("Wrap to zero did not set the overflow flag");

	chk_irq_mask: assert property ( // R09
		!intc_ff[`T8SP_INTCTL_EN] && stat_ff == 2'h0 |=> !irq
	) else $error("Masked overflow raised the interrupt");

	chk_sleep_halt: assert property ( // R11
		sleep_mode && !wr_cnt |-> !ovf ##1 $stable(cnt_ff)
	) else $error("Counter moved during sleep");

	chk_pre_clear: assert property ( // R15
		wr_cnt && !opt_ff.scaler_assign |=> pre_ff == '0
	) else $error("Count write left the prescaler set");

	chk_wdt_clear: assert property ( // R16
		watchdog_clear_op && opt_ff.scaler_assign |=> pre_ff == '0
	) else $error("Watchdog clear left the prescaler set");

	chk_wdt_direct: assert property ( // R14
		!opt_ff.scaler_assign && watchdog_tick |=> watchdog_timeout
	) else $error("Unscaled watchdog tick was lost");

	chk_ratio_div: assert property ( // R06
		!opt_ff.count_source_select && !opt_ff.scaler_assign && cnt_tick
		|-> (pre_ff & rmask) == rmask && instr_tick
	) else $error("Timer ticked off the prescale ratio");

	chk_rdata_idle: assert property ( // R05
		!req.rd
		|=> rdata == 8'h00
	) else $error("Read data stood without a read");

	chk_read_count: assert property ( // R01
		req.rd && req.addr == `T8SP_ADDR_COUNT
		|=> rdata == $past(cnt_ff)
	) else $error("Count read returned a stale value");

	chk_pre_hidden: assert property ( // R05
		req.rd && req.addr != `T8SP_ADDR_COUNT && req.addr != `T8SP_ADDR_INTCTL
		&& req.addr != `T8SP_ADDR_OPTION && req.addr != `T8SP_ADDR_PINDIR
		&& req.addr != `T8SP_ADDR_STAT && req.addr != `T8SP_ADDR_MASK |=> rdata == 8'h00
	) else $error("Unmapped read returned data");

	chk_opt_write: assert property ( // R17
		req.wr && req.addr == `T8SP_ADDR_OPTION
		|=> opt_ff == $past(req.wdata)
	) else $error("Option write did not take effect");

	chk_flag_sticky: assert property ( // R10
		intc_ff[`T8SP_INTCTL_FLAG] && !(req.wr && req.addr == `T8SP_ADDR_INTCTL)
		|=> intc_ff[`T8SP_INTCTL_FLAG]
	) else $error("Overflow flag cleared by hardware");

	chk_flag_source: assert property ( // R08
		!intc_ff[`T8SP_INTCTL_FLAG] && !ovf && !(req.wr && req.addr == `T8SP_ADDR_INTCTL)
		|=> !intc_ff[`T8SP_INTCTL_FLAG]
	) else $error("Overflow flag set without a wrap");

	chk_irq_unmasked: assert property ( // R09
		intc_ff[`T8SP_INTCTL_FLAG] && intc_ff[`T8SP_INTCTL_EN]
		|=> irq
	) else $error("Enabled overflow did not raise the interrupt");

	chk_stat_clear: assert property ( // R08
		req.rd && req.addr == `T8SP_ADDR_STAT && !cnt_tick
		|=> stat_ff == `T8SP_EV_RESET
	) else $error("Status read did not clear the events");

	chk_set_wins: assert property ( // R08
		ovf
		|=> intc_ff[`T8SP_INTCTL_FLAG] && stat_ff[`T8SP_EV_OVF]
	) else $error("Overflow event was lost");

	chk_undivided: assert property ( // R14
		opt_ff.scaler_assign && !opt_ff.count_source_select && cnt_tick
		|-> instr_tick
	) else $error("Counter divided while prescaler serves watchdog");

	chk_wdt_scaled: assert property ( // R14
		opt_ff.scaler_assign && watchdog_tick && (pre_ff & rmask) != rmask
		|=> !watchdog_timeout
	) else $error("Watchdog timeout before the postscale wrap");

	chk_wdt_wrap: assert property ( // R14
		opt_ff.scaler_assign && pre_wrap && !watchdog_clear_op
		|=> watchdog_timeout
	) else $error("Postscale wrap gave no watchdog timeout");

	chk_pre_idle: assert property ( // R13
		!opt_ff.scaler_assign && !opt_ff.count_source_select && !instr_tick && !wr_cnt
		|=> $stable(pre_ff)
	) else $error("Prescaler moved without a counter tick");

	chk_sleep_pre: assert property ( // R11
		sleep_mode && !opt_ff.scaler_assign && !wr_cnt
		|=> $stable(pre_ff)
	) else $error("Counter prescaler moved during sleep");

	chk_hold_block: assert property ( // R02
		hold_ff != t8sp_pkg::hold_run && !wr_cnt
		|=> $stable(cnt_ff)
	) else $error("Count moved while inhibited");

	chk_hold_exit: assert property ( // R02
		hold_ff == t8sp_pkg::hold_second && instr_tick && !wr_cnt
		|=> hold_ff == t8sp_pkg::hold_run
	) else $error("Inhibit lasted past two instruction cycles");

	chk_phase_step: assert property ( // R12
		1'b1
		|=> ph_ff == $past(ph_ff) + 2'h1
	) else $error("Phase counter skipped a phase");

	chk_ext_count: assert property ( // R03
		opt_ff.count_source_select && ext_tick && !sleep_mode && !wr_cnt
		&& hold_ff == t8sp_pkg::hold_run |=> cnt_ff == $past(cnt_ff) + 8'h01
	) else $error("External edge was not counted");

	chk_ext_only: assert property ( // R03
		opt_ff.count_source_select && !ext_tick && !wr_cnt
		|=> $stable(cnt_ff)
	) else $error("Counter mode advanced without an edge");

	chk_src_timer: assert property ( // R01
		!opt_ff.count_source_select && !instr_tick && !wr_cnt
		|=> $stable(cnt_ff)
	) else $error("Timer mode advanced off the instruction cycle");

endmodule

// ### bench/t8sp_pulse_src.sv
// Purpose: Pulse source for the external count pin
// Assumes: Pin idles low between bursts
// Notes: Hold time sets how many clocks each pin level lasts
module t8sp_pulse_src (
	input wire logic clk,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin = 1'h0;
	// Three clocks or more per level, so phase sampling never misses one
	task automatic burst(input int n, input int hold);
		repeat (n) begin
			repeat (hold) @(posedge clk);
			pin <= 1'h1;
			repeat (hold) @(posedge clk);
			pin <= 1'h0;
		end
	endtask
endmodule

// ### bench/t8sp_top_bench.sv
// Purpose: Self-checking bench for the shared-prescaler timer
// Assumes: Read data stands one cycle after the read strobe
// Notes: Count deltas span whole instruction cycles, so phase never matters
module t8sp_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, pin, sleep_mode, wclr, wtick, wto, irq;
	logic [7:0] rdata, d;
	t8sp_pkg::t8sp_req_t req;
	int err_count = 0;
	int comparisons = 0;
	int wto_n = 0;

	t8sp_top t8sp_top_inst (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
		.ext_count_pin(pin), .sleep_mode(sleep_mode), .watchdog_clear_op(wclr),
		.watchdog_tick(wtick), .watchdog_timeout(wto), .irq(irq));
	t8sp_pulse_src t8sp_pulse_src_inst (.clk(clk), .pin(pin));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		if (wto === 1'h1)
			wto_n <= wto_n + 1;
	end

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: 1'h1, rd: 1'h0};
		@(posedge clk);
		req.wr <= 1'h0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge clk);
		req.rd <= 1'h0;
		#1 v = rdata;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		reg_rd(a, v);
		chk(v, e);
	endtask

	// Second read lands exactly clks edges after the first
	task automatic delta(input int clks, input logic [7:0] e);
		logic [7:0] a, b;
		reg_rd(8'h01, a);
		repeat (clks - 2) @(posedge clk);
		reg_rd(8'h01, b);
		chk(b - a, e);
	endtask

	task automatic pulses(input int n, input int hold, input logic [7:0] e);
		logic [7:0] a, b;
		reg_rd(8'h01, a);
		t8sp_pulse_src_inst.burst(n, hold);
		repeat (8) @(posedge clk);
		reg_rd(8'h01, b);
		chk(b - a, e);
	endtask

	task automatic ticks(input int n, input logic [7:0] e);
		int n0;
		n0 = wto_n;
		repeat (n) begin
			@(posedge clk);
			wtick <= 1'h1;
			@(posedge clk);
			wtick <= 1'h0;
			repeat (2) @(posedge clk);
		end
		repeat (2) @(posedge clk);
		chk(8'(wto_n - n0), e);
	endtask

	task automatic wd_clear();
		@(posedge clk);
		wclr <= 1'h1;
		@(posedge clk);
		wclr <= 1'h0;
	endtask

	task automatic irq_now(input logic [7:0] e);
		@(posedge clk);
		#1 chk({7'h00, irq}, e);
	endtask

	task automatic summarize();
		$display("err_count=%0d comparisons=%0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		rst_n = 1'h0;
		req = '0;
		sleep_mode = 1'h0;
		wclr = 1'h0;
		wtick = 1'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		rc(8'h81, 8'hFF);
		rc(8'h01, 8'h00);
		reg_wr(8'h85, 8'hFF);
		rc(8'h85, 8'h3F);
		rc(8'h42, 8'h00);
		reg_wr(8'h81, 8'h08);
		rc(8'h81, 8'h08);
		delta(40, 8'h0A);
		reg_wr(8'h01, 8'h10);
		repeat (39) @(posedge clk);
		rc(8'h01, 8'h18);
		reg_wr(8'h01, 8'hFE);
		sleep_mode <= 1'h1;
		repeat (40) @(posedge clk);
		rc(8'h01, 8'hFE);
		rc(8'h0B, 8'h00);
		sleep_mode <= 1'h0;
		repeat (20) @(posedge clk);
		rc(8'h0B, 8'h04);
		chk({7'h00, irq}, 8'h00);
		reg_wr(8'h0B, 8'h24);
		irq_now(8'h01);
		reg_wr(8'h0B, 8'h20);
		irq_now(8'h00);
		reg_rd(8'h90, d);
		chk(d & 8'h01, 8'h01);
		reg_rd(8'h90, d);
		chk(d & 8'h01, 8'h00);
		reg_wr(8'h0B, 8'h00);
		reg_wr(8'h91, 8'h01);
		for (int n = 0; n < 1100 && irq !== 1'h1; n++)
			@(posedge clk);
		chk({7'h00, irq}, 8'h01);
		reg_rd(8'h90, d);
		irq_now(8'h00);
		reg_wr(8'h91, 8'h00);
		reg_wr(8'h81, 8'h00);
		ticks(4, 8'h04);
		reg_wr(8'h01, 8'h00);
		wd_clear();
		reg_wr(8'h81, 8'h09);
		wd_clear();
		ticks(8, 8'h02);
		wd_clear();
		for (int r = 0; r < 8; r++) begin
			reg_wr(8'h81, 8'(r));
			delta(1024, 8'(256 >> (r + 1)));
		end
		reg_wr(8'h81, 8'h28);
		pulses(5, 3, 8'h05);
		reg_wr(8'h81, 8'h38);
		repeat (8) @(posedge clk);
		pulses(5, 6, 8'h05);
		reg_wr(8'h81, 8'h21);
		reg_wr(8'h01, 8'h00);
		repeat (8) @(posedge clk);
		pulses(8, 3, 8'h02);
		summarize();
	end
endmodule
